/* hdl/smc_pkg.sv */
package smc_pkg;
  // clocking and timing
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned CLK_NS = 4;
  localparam int unsigned STEP_PW_NS = 2000;
  // least pulse width, rounded up to whole cycles
  localparam int unsigned STEP_PW_CYC = (STEP_PW_NS + CLK_NS - 1) / CLK_NS;

  // widths
  localparam int ADDR_W = 6;
  localparam int RATE_W = 14;
  localparam int ACC_W = 16;

  // speed profile limits and ramp floor (max rate shifted right by 3)
  localparam logic [31:0] PPS_MIN = 32'h0000_0001;
  localparam logic [31:0] PPS_MAX = 32'h0000_2710;
  localparam int RATE_FLOOR_SH = 3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_ARG0 = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_ARG1 = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_CMD = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 6'h0c;
  localparam logic [ADDR_W-1:0] OFF_POS1 = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_POS2 = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_STEPS1 = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_STEPS2 = 6'h1c;
  localparam logic [ADDR_W-1:0] OFF_STAT = 6'h20;

  // command word fields
  localparam int OP_LSB = 0;
  localparam int SEL_LSB = 8;
  localparam int FLAG_LSB = 16;

  // command opcodes
  localparam logic [2:0] OP_SPEED = 3'h1;
  localparam logic [2:0] OP_REL = 3'h2;
  localparam logic [2:0] OP_ABS = 3'h3;
  localparam logic [2:0] OP_STOP = 3'h4;
  localparam logic [2:0] OP_HOME = 3'h5;
  localparam logic [2:0] OP_SWRST = 3'h6;

  // channel selectors (decimal 1, 2, 11, 21, 32)
  localparam logic [7:0] SEL_CH1 = 8'h01;
  localparam logic [7:0] SEL_CH2 = 8'h02;
  localparam logic [7:0] SEL_CH1_FULL = 8'h0b;
  localparam logic [7:0] SEL_CH1_HALF = 8'h15;
  localparam logic [7:0] SEL_CH2_CTRL = 8'h20;

  // status register bits
  localparam int ST_BUSY1 = 0;
  localparam int ST_BUSY2 = 1;
  localparam int ST_ABS1 = 2;
  localparam int ST_ABS2 = 3;
  localparam int ST_PROF1 = 4;
  localparam int ST_PROF2 = 5;
  localparam int ST_MODE = 6;
  localparam int ST_ERR = 8;

  // unipolar half-step table, entry i at bits [4*i+:4]
  localparam logic [31:0] PHASE_TAB = 32'h98c4_6231;
  localparam logic [2:0] PH_HALF = 3'h1;
  localparam logic [2:0] PH_FULL = 3'h2;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {MODE_CTRL, MODE_FULL, MODE_HALF} smc_mode_t;
endpackage

/* hdl/smc_top.sv */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// one motion channel: trapezoidal rate generator and step bookkeeping

module smc_chan #(
  parameter int unsigned CLK_HZ = smc_pkg::CLK_HZ
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // commands
  input wire logic start,
  input wire logic start_dir,
  input wire logic [31:0] start_cnt,
  input wire logic stop,
  input wire logic home,
  // speed profile
  input wire logic [smc_pkg::RATE_W-1:0] pps,
  input wire logic [smc_pkg::ACC_W-1:0] acc,
  // state
  output logic running,
  output logic dir,
  output logic step_tick,
  output logic step_lvl,
  output logic done,
  output logic [31:0] pos,
  output logic [31:0] steps_done
);
  localparam logic [31:0] HZ = 32'(CLK_HZ);
  localparam logic [15:0] PW = 16'(smc_pkg::STEP_PW_CYC);
  logic running_r, dir_r, done_r, lvl_r, up_dir_r, adj;
  logic [31:0] rem_r, pacc_r, err_r, pos_r, steps_r, sum;
  logic [smc_pkg::RATE_W-1:0] rate_r, rfloor, span;
  logic [smc_pkg::ACC_W-1:0] up_r;
  logic [15:0] pw_r;

  // rate floor is an eighth of the top rate, never zero
  always_comb begin
    rfloor = pps >> smc_pkg::RATE_FLOOR_SH;
    if (rfloor == '0) begin
      rfloor[0] = 1'b1;
    end
    span = pps - rfloor;
    sum = pacc_r + 32'(rate_r);
    adj = (acc != '0) && (err_r >= 32'(acc));
    step_tick = running_r && !stop && (sum >= HZ);
  end

  // phase accumulator: one step each time the sum wraps the clock rate
  always_ff @(posedge aclk) begin
    if (!aresetn || start) begin
      pacc_r <= '0;
    end else if (step_tick) begin
      pacc_r <= sum - HZ;
    end else if (running_r) begin
      pacc_r <= sum;
    end
  end

  // move bookkeeping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      running_r <= 1'b0;
      dir_r <= 1'b0;
      done_r <= 1'b0;
      rem_r <= '0;
      steps_r <= '0;
    end else begin
      done_r <= 1'b0;
      if (stop) begin
        running_r <= 1'b0;
      end else if (start) begin
        dir_r <= start_dir;
        rem_r <= start_cnt;
        steps_r <= '0;
        running_r <= (start_cnt != '0);
        done_r <= (start_cnt == '0);
      end else if (step_tick) begin
        rem_r <= rem_r - 1'b1;
        steps_r <= steps_r + 1'b1;
        if (rem_r == 32'h0000_0001) begin
          running_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  // position counter, counts what was actually output
  always_ff @(posedge aclk) begin
    if (!aresetn || home) begin
      pos_r <= '0;
    end else if (step_tick) begin
      pos_r <= dir_r ? pos_r - 1'b1 : pos_r + 1'b1;
    end
  end

  // velocity profile: each ramp step owes span/acc of rate, paid one
  // unit per cycle between steps; steps are thousands of cycles apart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_r <= '0;
      up_r <= '0;
      err_r <= '0;
      up_dir_r <= 1'b0;
    end else if (start) begin
      rate_r <= (acc == '0) ? pps : rfloor;
      up_r <= '0;
      err_r <= '0;
      up_dir_r <= 1'b1;
    end else if (step_tick && acc != '0) begin
      if (rem_r - 1'b1 <= 32'(up_r) && up_r != '0) begin
        up_r <= up_r - 1'b1;
        err_r <= err_r + 32'(span);
        up_dir_r <= 1'b0;
      end else if (up_r < acc) begin
        up_r <= up_r + 1'b1;
        err_r <= err_r + 32'(span);
        up_dir_r <= 1'b1;
      end
    end else if (adj) begin
      err_r <= err_r - 32'(acc);
      if (up_dir_r && rate_r < pps) begin
        rate_r <= rate_r + 1'b1;
      end else if (!up_dir_r && rate_r > rfloor) begin
        rate_r <= rate_r - 1'b1;
      end
    end
  end

  // stretch each step into a pulse an external driver can see
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pw_r <= '0;
      lvl_r <= 1'b0;
    end else if (step_tick) begin
      pw_r <= PW;
      lvl_r <= 1'b1;
    end else if (pw_r != '0) begin
      pw_r <= pw_r - 1'b1;
      lvl_r <= (pw_r != 16'h0001);
    end
  end

  assign running = running_r;
  assign dir = dir_r;
  assign step_lvl = lvl_r;
  assign done = done_r;
  assign pos = pos_r;
  assign steps_done = steps_r;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_last_step_done: assert property (
    step_tick && rem_r == 32'h0000_0001 |=> done && !running)
    else $error("last step did not finish the move");
  a_zero_move: assert property (
    start && !stop && start_cnt == '0 |=> done && !running)
    else $error("empty move did not complete at once");
  a_stop_halts: assert property (
    stop |=> !running && !done ##1 !step_tick)
    else $error("stop did not end motion");
  a_pos_follow: assert property (
    step_tick && !home |=> pos == ($past(dir) ? $past(pos) - 32'h1
                                             : $past(pos) + 32'h1))
    else $error("position does not follow steps");
  a_rate_band: assert property (
    running && !start |-> rate_r <= pps && rate_r >= rfloor)
    else $error("rate left the trapezoid band");
  a_step_space: assert property (
    step_tick |=> !step_tick [*8])
    else $error("steps closer than the rate allows");
endmodule

////////////////////////////////////////////////////////////////////////////////
module smc_top #(
  parameter int unsigned CLK_HZ = smc_pkg::CLK_HZ
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [smc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [smc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // motor outputs, bit 0 is output five
  output logic [3:0] motor_out
);
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic aw_hold_r, w_hold_r, wr_fire, rd_ok, cmd_err_r, spd_v, swrst;
  logic [1:0] bresp_r, rresp_r;
  logic [smc_pkg::ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r, arg0_r, arg1_r, flags_r, rd_data;
  logic [31:0] flag_clr, flag_set, stat, mag;
  logic [3:0] wstrb_r, motor_out_r, motor_out_nxt;
  logic cmd_v, is_move, mv_ok, mv_ch, ch_ok, ch, accepted;
  logic [2:0] op, ph_r;
  logic [7:0] sel;
  logic [4:0] fidx;
  logic [32:0] diff;
  smc_pkg::smc_mode_t mode_r, mv_mode;
  logic [1:0] start_v, stop_v, home_v, run, dir_w, tick, lvl, done_w;
  logic [1:0] abs_r, prof_ok_r;
  logic [1:0][31:0] pos_w, steps_w;
  logic [1:0][4:0] fidx_r;
  logic [1:0][smc_pkg::RATE_W-1:0] pps_r;
  logic [1:0][smc_pkg::ACC_W-1:0] acc_r;

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite write side: address and data taken in either order
  assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= smc_pkg::RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        awaddr_r <= s_axi_awaddr;
        aw_hold_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_hold_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        // read-only words accept and drop writes; holes decode-error
        bresp_r <= (awaddr_r <= smc_pkg::OFF_STAT && awaddr_r[1:0] == 2'h0)
                   ? smc_pkg::RESP_OKAY : smc_pkg::RESP_DECERR;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // argument words with byte strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arg0_r <= '0;
      arg1_r <= '0;
    end else if (wr_fire) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_r[b] && awaddr_r == smc_pkg::OFF_ARG0) begin
          arg0_r[8*b +: 8] <= wdata_r[8*b +: 8];
        end
        if (wstrb_r[b] && awaddr_r == smc_pkg::OFF_ARG1) begin
          arg1_r[8*b +: 8] <= wdata_r[8*b +: 8];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // command decode; a command acts in the cycle its write completes
  always_comb begin
    cmd_v = wr_fire && awaddr_r == smc_pkg::OFF_CMD && wstrb_r[0];
    op = wdata_r[smc_pkg::OP_LSB +: 3];
    sel = wdata_r[smc_pkg::SEL_LSB +: 8];
    fidx = wdata_r[smc_pkg::FLAG_LSB +: 5];
    is_move = (op == smc_pkg::OP_REL) || (op == smc_pkg::OP_ABS);
    mv_ok = 1'b1;
    mv_ch = 1'b0;
    mv_mode = smc_pkg::MODE_CTRL;
    case (sel)
      smc_pkg::SEL_CH1: mv_mode = smc_pkg::MODE_CTRL;
      smc_pkg::SEL_CH1_FULL: mv_mode = smc_pkg::MODE_FULL;
      smc_pkg::SEL_CH1_HALF: mv_mode = smc_pkg::MODE_HALF;
      smc_pkg::SEL_CH2_CTRL: mv_ch = 1'b1;
      default: mv_ok = 1'b0;
    endcase
    ch_ok = (sel == smc_pkg::SEL_CH1) || (sel == smc_pkg::SEL_CH2);
    ch = (sel == smc_pkg::SEL_CH2);
    // absolute target minus where the channel stands now
    if (op == smc_pkg::OP_ABS) begin
      diff = {arg0_r[31], arg0_r} - {pos_w[mv_ch][31], pos_w[mv_ch]};
    end else begin
      diff = {arg0_r[31], arg0_r};
    end
    mag = diff[32] ? 32'(-diff) : diff[31:0];
    start_v = '0;
    // a busy channel ignores moves; driver mode owns outputs seven and eight
    if (cmd_v && is_move && mv_ok && !run[mv_ch] && prof_ok_r[mv_ch]) begin
      if (mv_ch && !(run[0] && mode_r != smc_pkg::MODE_CTRL)) begin
        start_v[1] = 1'b1;
      end else if (!mv_ch && (mv_mode == smc_pkg::MODE_CTRL || !run[1])) begin
        start_v[0] = 1'b1;
      end
    end
    swrst = cmd_v && op == smc_pkg::OP_SWRST;
    spd_v = cmd_v && op == smc_pkg::OP_SPEED && ch_ok &&
            arg0_r >= smc_pkg::PPS_MIN && arg0_r <= smc_pkg::PPS_MAX;
    stop_v = {2{swrst}};
    home_v = '0;
    if (cmd_v && ch_ok && op == smc_pkg::OP_STOP) begin
      stop_v[ch] = 1'b1;
    end
    if (cmd_v && ch_ok && op == smc_pkg::OP_HOME) begin
      home_v[ch] = 1'b1;
    end
    accepted = (start_v != '0) || spd_v || swrst || (stop_v != '0) ||
               (home_v != '0);
  end

  //////////////////////////////////////////////////////////////////////////////
  // speed profiles: only the bus reset clears them, soft reset keeps them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prof_ok_r <= '0;
      pps_r <= '0;
      acc_r <= '0;
    end else if (spd_v) begin
      prof_ok_r[ch] <= 1'b1;
      pps_r[ch] <= arg0_r[smc_pkg::RATE_W-1:0];
      acc_r[ch] <= arg1_r[smc_pkg::ACC_W-1:0];
    end
  end

  // per-channel move attributes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= smc_pkg::MODE_CTRL;
      abs_r <= '0;
      fidx_r <= '0;
      cmd_err_r <= 1'b0;
    end else begin
      if (start_v[0]) begin
        mode_r <= mv_mode;
      end else if (start_v[1] && !run[0]) begin
        mode_r <= smc_pkg::MODE_CTRL;
      end
      for (int c = 0; c < 2; c++) begin
        if (start_v[c]) begin
          abs_r[c] <= (op == smc_pkg::OP_ABS);
          fidx_r[c] <= fidx;
        end else if (done_w[c] || stop_v[c]) begin
          abs_r[c] <= 1'b0;
        end
      end
      if (cmd_v) begin
        cmd_err_r <= !accepted;
      end
    end
  end

  // completion flags: a finish in the same cycle as a clear still sets
  always_comb begin
    flag_clr = '0;
    if (start_v != '0) begin
      flag_clr[fidx] = 1'b1;
    end
    if (swrst) begin
      flag_clr = '1;
    end
    flag_set = (32'(done_w[0]) << fidx_r[0]) | (32'(done_w[1]) << fidx_r[1]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= '0;
    end else begin
      flags_r <= (flags_r & ~flag_clr) | flag_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // the two motion channels
  for (genvar g = 0; g < 2; g++) begin : g_chan
    smc_chan #(.CLK_HZ(CLK_HZ)) u_chan (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(start_v[g]),
      .start_dir(diff[32]),
      .start_cnt(mag),
      .stop(stop_v[g]),
      .home(home_v[g]),
      .pps(pps_r[g]),
      .acc(acc_r[g]),
      .running(run[g]),
      .dir(dir_w[g]),
      .step_tick(tick[g]),
      .step_lvl(lvl[g]),
      .done(done_w[g]),
      .pos(pos_w[g]),
      .steps_done(steps_w[g])
    );
  end

  // driver phase walks the table, by two entries in full-step mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_r <= '0;
    end else if (tick[0] && mode_r != smc_pkg::MODE_CTRL) begin
      if (mode_r == smc_pkg::MODE_HALF) begin
        ph_r <= dir_w[0] ? ph_r - smc_pkg::PH_HALF : ph_r + smc_pkg::PH_HALF;
      end else begin
        ph_r <= dir_w[0] ? ph_r - smc_pkg::PH_FULL : ph_r + smc_pkg::PH_FULL;
      end
    end
  end

  // output pins: phases in driver mode, else direction and pulse pairs
  always_comb begin
    if (mode_r != smc_pkg::MODE_CTRL) begin
      motor_out_nxt = smc_pkg::PHASE_TAB[{ph_r, 2'b00} +: 4];
    end else begin
      motor_out_nxt = {lvl[1], dir_w[1], lvl[0], dir_w[0]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      motor_out_r <= '0;
    end else begin
      motor_out_r <= motor_out_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite read side; position may be read mid-move
  always_comb begin
    stat = '0;
    stat[smc_pkg::ST_BUSY1] = run[0];
    stat[smc_pkg::ST_BUSY2] = run[1];
    stat[smc_pkg::ST_ABS1] = abs_r[0];
    stat[smc_pkg::ST_ABS2] = abs_r[1];
    stat[smc_pkg::ST_PROF1] = prof_ok_r[0];
    stat[smc_pkg::ST_PROF2] = prof_ok_r[1];
    stat[smc_pkg::ST_MODE +: 2] = mode_r;
    stat[smc_pkg::ST_ERR] = cmd_err_r;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      smc_pkg::OFF_ARG0: rd_data = arg0_r;
      smc_pkg::OFF_ARG1: rd_data = arg1_r;
      smc_pkg::OFF_CMD: rd_data = '0;
      smc_pkg::OFF_FLAGS: rd_data = flags_r;
      smc_pkg::OFF_POS1: rd_data = pos_w[0];
      smc_pkg::OFF_POS2: rd_data = pos_w[1];
      smc_pkg::OFF_STEPS1: rd_data = steps_w[0];
      smc_pkg::OFF_STEPS2: rd_data = steps_w[1];
      smc_pkg::OFF_STAT: rd_data = stat;
      default: begin
        rd_data = '0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= smc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_data;
      rresp_r <= rd_ok ? smc_pkg::RESP_OKAY : smc_pkg::RESP_DECERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign motor_out = motor_out_r;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_abs_lock: assert property (
    cmd_v && is_move && mv_ok && !mv_ch && abs_r[0] |-> !start_v[0])
    else $error("move accepted during absolute move");
  a_dir_pin: assert property (
    mode_r == smc_pkg::MODE_CTRL |=> motor_out[0] == $past(dir_w[0]))
    else $error("direction pin does not follow channel one");
  a_flag_set: assert property (
    done_w[0] |=> flags_r[$past(fidx_r[0])])
    else $error("completion flag not set");
  a_flag_clear: assert property (
    start_v[0] && !done_w[1] |=> !flags_r[$past(fidx)])
    else $error("completion flag not cleared on issue");
  a_ch2_ctrl: assert property (
    start_v[1] |-> !(run[0] && mode_r != smc_pkg::MODE_CTRL))
    else $error("channel two started over driver outputs");
  a_prof_keep: assert property (
    swrst |=> pps_r == $past(pps_r) && prof_ok_r == $past(prof_ok_r))
    else $error("soft reset disturbed the speed profile");

  c_rel_done: cover property (start_v[0] && op == smc_pkg::OP_REL
                              ##[1:1000] done_w[0]);
  c_abs_ch2: cover property (start_v[1] && op == smc_pkg::OP_ABS);
  c_half_step: cover property (tick[0] && mode_r == smc_pkg::MODE_HALF);
  c_stop_run: cover property (run[0] && stop_v[0]);
  c_ch2_ramp: cover property (tick[1] && acc_r[1] != '0);
endmodule

`default_nettype wire

/* sim/smc_drv_model.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// external step/dir driver: keeps a signed pulse tally per channel
module smc_drv_model (
  // clock, reset and motor lines
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] motor_out,
  // signed pulse tallies
  output logic signed [31:0] tally1,
  output logic signed [31:0] tally2
);
  logic [3:0] prev_r;
  // count on the rising step edge; direction high means backward
  always_ff @(posedge aclk) begin
    prev_r <= motor_out;
    if (!aresetn) begin
      tally1 <= 32'h0;
      tally2 <= 32'h0;
    end else begin
      if (motor_out[1] && !prev_r[1])
        tally1 <= tally1 + (motor_out[0] ? -1 : 1);
      if (motor_out[3] && !prev_r[3])
        tally2 <= tally2 + (motor_out[2] ? -1 : 1);
    end
  end
endmodule
`default_nettype wire

/* sim/tb_stepper_motion_controller.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_stepper_motion_controller;
  logic aclk, aresetn, awv, wv, bry, arv, rry, awr, wr_r, bv, arr, rv;
  logic [5:0] awa, ara;
  logic [31:0] wd, rdat, rd_v;
  logic [1:0] bresp, rresp, rs_v;
  logic [3:0] motor_out;
  logic signed [31:0] tally1, tally2;
  int err_count, checks_done;
  // 10 MHz step timebase keeps a step longer than its 500-cycle pulse
  smc_top #(.CLK_HZ(10_000_000)) smc_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .motor_out(motor_out));
  smc_drv_model smc_drv_model_i (.aclk(aclk), .aresetn(aresetn),
    .motor_out(motor_out), .tally1(tally1), .tally2(tally2));
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // write: both channels offered together, each dropped once taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end while (!bv);
    // bready is left high; each call drives it high again and none lowers it
  endtask
  task automatic rd(input logic [5:0] a);
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rd_v = rdat;
    rs_v = rresp;
  endtask
  task automatic cmd(input logic [2:0] op, input logic [7:0] sel,
    input logic [4:0] fl, input logic [31:0] a0);
    wr(smc_pkg::OFF_ARG0, a0);
    wr(smc_pkg::OFF_CMD, {11'h0, fl, sel, 5'h0, op});
  endtask
  task automatic wait_flag(input int b);
    do rd(smc_pkg::OFF_FLAGS); while (rd_v[b] === 1'b0);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // watchdog, about two and a half times the expected run
  initial begin
    #320000;
    err_count++;
    give_verdict();
  end
  initial begin
    {aresetn, awv, wv, bry, arv, rry, awa, ara, wd} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(smc_pkg::OFF_STAT); chk("stat", 32'h0, rd_v);
    rd(6'h24); chk("decerr", 32'h3, {30'h0, rs_v});
    wr(smc_pkg::OFF_ARG1, 32'h0);
    cmd(smc_pkg::OP_SPEED, 8'h01, 5'h0, 32'h2711);
    rd(smc_pkg::OFF_STAT); chk("bad_rate", 32'h100, rd_v);
    cmd(smc_pkg::OP_SPEED, 8'h01, 5'h0, 32'h2710);
    cmd(smc_pkg::OP_SPEED, 8'h02, 5'h0, 32'h2710);
    rd(smc_pkg::OFF_STAT); chk("prof", 32'h30, rd_v & 32'h3f);
    cmd(smc_pkg::OP_REL, 8'h01, 5'h5, 32'h0);
    wait_flag(5);
    cmd(smc_pkg::OP_REL, 8'h01, 5'h5, 32'hffff_fffd);
    cmd(smc_pkg::OP_REL, 8'h01, 5'h5, 32'h7);
    rd(smc_pkg::OFF_FLAGS); chk("clr", 32'h0, rd_v & 32'h20);
    wait_flag(5);
    rd(smc_pkg::OFF_POS1); chk("pos1", 32'hffff_fffd, rd_v);
    chk("tally1", 32'hffff_fffd, tally1);
    cmd(smc_pkg::OP_REL, 8'h20, 5'h6, 32'h2);
    wait_flag(6);
    rd(smc_pkg::OFF_POS2); chk("pos2", 32'h2, rd_v);
    chk("tally2", 32'h2, tally2);
    cmd(smc_pkg::OP_ABS, 8'h01, 5'h7, 32'h2);
    cmd(smc_pkg::OP_REL, 8'h01, 5'h7, 32'h9);
    rd(smc_pkg::OFF_POS1); chk("run", 32'hffff_fffd, rd_v);
    wait_flag(7);
    rd(smc_pkg::OFF_POS1); chk("abs", 32'h2, rd_v);
    chk("tally_abs", 32'h2, tally1);
    cmd(smc_pkg::OP_HOME, 8'h01, 5'h0, 32'h0);
    rd(smc_pkg::OFF_POS1); chk("home", 32'h0, rd_v);
    cmd(smc_pkg::OP_REL, 8'h01, 5'h8, 32'h64);
    repeat (2500) @(posedge aclk);
    cmd(smc_pkg::OP_STOP, 8'h01, 5'h0, 32'h0);
    repeat (600) @(posedge aclk);
    rd(smc_pkg::OFF_POS1); chk("stop", tally1 - 2, rd_v);
    rd(smc_pkg::OFF_STEPS1);
    chk("steps1", 32'h2, rd_v);
    rd(smc_pkg::OFF_FLAGS);
    chk("stop_flag", 32'h0, rd_v & 32'h100);
    // ramped profile on channel two: first step comes at an eighth of top rate
    wr(smc_pkg::OFF_ARG1, 32'h2);
    cmd(smc_pkg::OP_SPEED, 8'h02, 5'h0, 32'h2710);
    cmd(smc_pkg::OP_ABS, 8'h20, 5'ha, 32'h6);
    repeat (7000) @(posedge aclk);
    rd(smc_pkg::OFF_POS2);
    chk("ramp_floor", 32'h2, rd_v);
    wait_flag(10);
    rd(smc_pkg::OFF_POS2);
    chk("ramp_abs", 32'h6, rd_v);
    chk("tally_ramp", 32'h6, tally2);
    cmd(smc_pkg::OP_SWRST, 8'h01, 5'h0, 32'h0);
    rd(smc_pkg::OFF_STAT); chk("keep", 32'h30, rd_v & 32'h3f);
    cmd(smc_pkg::OP_REL, 8'h0b, 5'h9, 32'h1);
    wait_flag(9);
    chk("wave", 32'h2, {28'h0, motor_out});
    rd(smc_pkg::OFF_STAT);
    chk("mode", 32'h40, rd_v & 32'hc0);
    cmd(smc_pkg::OP_REL, 8'h15, 5'hb, 32'hffff_ffff);
    wait_flag(11);
    chk("half", 32'h3, {28'h0, motor_out});
    rd(smc_pkg::OFF_POS1);
    chk("pos_half", 32'h2, rd_v);
    give_verdict();
  end
endmodule
`default_nettype wire
